// ---- hdl/adss_pkg.sv ----
// Package of constants and types shared by the converter sweep sequencer.
package adss_pkg;

  // ---------------------------------------------------------------------------
  // Register bus geometry and register offsets.
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 16;
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h1;
  localparam logic [3:0]  ADDR_MASK   = 4'h2;
  localparam logic [3:0]  ADDR_INFO   = 4'h3;
  localparam int unsigned RESULT_SEL  = 3;     // Address bit that selects the result bank.

  // ---------------------------------------------------------------------------
  // Control register layout, least significant field last.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sweep_len;           // Channels swept: 2, 4, 6 or 8.
    logic       input_group_select;  // Low: default pins, high: alternate pins.
    logic       sample_hold;         // High: sample-and-hold active.
    logic       res_10bit;           // Low: 8-bit, high: 10-bit conversion.
    logic [1:0] div_sel;             // Converter clock division.
    logic       mode;                // Low: single sweep, high: repeat sweep 0.
    logic       start;               // Conversion start flag.
  } adss_ctrl_t;

  localparam int unsigned CTRL_W     = $bits(adss_ctrl_t);
  localparam adss_ctrl_t  CTRL_RESET = '0;
  localparam logic        MODE_SINGLE = 1'h0;
  localparam logic        MODE_REPEAT = 1'h1;

  // Converter clock division codes; the unused code also runs undivided.
  localparam logic [1:0]  DIV_BY4   = 2'h0;
  localparam logic [1:0]  DIV_BY2   = 2'h1;
  localparam logic [1:0]  DIV_NONE  = 2'h2;
  localparam logic [1:0]  DIV4_LAST = 2'h3;

  // Status and mask layout, and their values after reset.
  localparam int unsigned STAT_DONE_BIT = 0;
  localparam logic        STAT_RESET    = 1'h0;
  localparam logic        MASK_RESET    = 1'h0;

  // ---------------------------------------------------------------------------
  // Converter clock cycles per channel and resolution widths.
  // ---------------------------------------------------------------------------
  localparam logic [5:0]  CYC_SH_8    = 6'h1c;  // 28 cycles.
  localparam logic [5:0]  CYC_SH_10   = 6'h21;  // 33 cycles.
  localparam logic [5:0]  CYC_NOSH_8  = 6'h31;  // 49 cycles.
  localparam logic [5:0]  CYC_NOSH_10 = 6'h3b;  // 59 cycles.
  localparam logic [3:0]  BITS_LO     = 4'h8;
  localparam logic [3:0]  BITS_HI     = 4'ha;
  localparam int unsigned RES_W       = 10;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CONV
  } adss_state_t;

endpackage

// ---- hdl/adss_sweep_sequencer.sv ----
// Sweep sequencer for a successive-approximation converter with register port.
//
// Functional notes
// - Converter clock is the source clock divided by four, by two, or undivided.
// - With sample-and-hold a channel takes 28 cycles at 8 bits, 33 at 10.
// - Without sample-and-hold a channel takes 49 cycles at 8 bits, 59 at 10.
// - Sweep covers the first 2, 4, 6 or 8 channels, starting at zero.
// - Alternate group replaces channels zero to four with its five pins.
// - Writing one to the start flag begins a sweep at channel zero.
// - Each finished channel's result goes to that channel's own result register.
// - Single sweep end sets the interrupt request, clears start, and stops.
// - Interrupt request clears when accepted or when software clears it.
// - Repeat sweep 0 continues until software writes zero to the start flag.
// - Repeat sweep 0 never sets the interrupt request.
// - Resolution bit low selects 8 bits, high selects 10 bits.
// - Group bit low selects default pins, high selects alternate pins.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module adss_sweep_sequencer
#(
  parameter int unsigned CHANNELS = 8,
  parameter int unsigned ALT_PINS = 5
)
(
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  input  wire logic [adss_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [adss_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [adss_pkg::DATA_W-1:0] rdata_o,
  output logic                             irq_o,
  input  wire logic                        irq_ack_i,
  input  wire logic                        comp_i,
  output logic      [adss_pkg::RES_W-1:0]  sar_code_o,
  output logic                             sample_o,
  output logic                             busy_o,
  output logic      [CHANNELS-1:0]         chan_sel_o,
  output logic      [ALT_PINS-1:0]         alt_sel_o
);

  localparam int unsigned DW = adss_pkg::DATA_W;
  localparam int unsigned RW = adss_pkg::RES_W;

  // ---------------------------------------------------------------------------
  // Elaboration check.
  // ---------------------------------------------------------------------------
  // The channel index and sweep length field are three and two bits wide.
  if (CHANNELS != 8 || ALT_PINS < 1 || ALT_PINS > CHANNELS) begin : g_bad_params
    $error("adss_sweep_sequencer: CHANNELS must be 8 and ALT_PINS 1 to CHANNELS.");
  end

  // ---------------------------------------------------------------------------
  // Declarations.
  // ---------------------------------------------------------------------------
  adss_pkg::adss_ctrl_t  ctrl;
  adss_pkg::adss_state_t state;
  logic                  status_done;
  logic                  mask_done;
  logic [2:0]            chan;
  logic [5:0]            conv_cnt;
  logic [3:0]            bit_idx;
  logic [1:0]            div_cnt;
  logic                  comp_meta;
  logic                  comp_sync;
  logic [RW-1:0]         result [CHANNELS];
  logic                  fad_tick;
  logic [5:0]            total_cyc;
  logic [3:0]            nbits;
  logic [5:0]            samp_end;
  logic [1:0]            step_ticks;
  logic [1:0]            step_ph;
  logic                  step;
  logic                  last_chan;
  logic                  chan_done;
  logic                  sweep_end;
  logic [RW-1:0]         next_code;
  logic                  wr_ctrl;
  logic                  wr_status;
  logic                  wr_mask;

  // ---------------------------------------------------------------------------
  // Input synchroniser and clock divider.
  // ---------------------------------------------------------------------------
  // The comparator answer comes from the analog side, so it is synchronised.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      comp_meta <= 1'h0;
      comp_sync <= 1'h0;
    end
    else
    begin
      comp_meta <= comp_i;
      comp_sync <= comp_meta;
    end
  end

  // Free-running divider counter from which the converter clock enable comes.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      div_cnt <= 2'h0;
    else
      div_cnt <= div_cnt + 2'h1;
  end

  // Converter clock enable per the selected division.
  always_comb
  begin
    case (ctrl.div_sel)
      adss_pkg::DIV_BY4: fad_tick = (div_cnt == adss_pkg::DIV4_LAST);
      adss_pkg::DIV_BY2: fad_tick = div_cnt[0];
      default:           fad_tick = 1'h1;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Conversion timing and successive approximation.
  // ---------------------------------------------------------------------------
  // Channel length, resolution and sweep end are picked from the control fields.
  always_comb
  begin
    if (ctrl.sample_hold)
      total_cyc = ctrl.res_10bit ? adss_pkg::CYC_SH_10 : adss_pkg::CYC_SH_8;
    else
      total_cyc = ctrl.res_10bit ? adss_pkg::CYC_NOSH_10 : adss_pkg::CYC_NOSH_8;
    nbits     = ctrl.res_10bit ? adss_pkg::BITS_HI : adss_pkg::BITS_LO;
    // The synchronised comparator lags three clocks, so fast ticks share a bit.
    case (ctrl.div_sel)
      adss_pkg::DIV_BY4: step_ticks = 2'h1;
      adss_pkg::DIV_BY2: step_ticks = 2'h2;
      default:           step_ticks = 2'h3;
    endcase
    samp_end  = total_cyc - 6'({2'h0, nbits} * {4'h0, step_ticks}) - 6'h01;
    step      = (conv_cnt > samp_end) && (step_ph == step_ticks - 2'h1);
    last_chan = (chan == {ctrl.sweep_len, 1'h1});
    chan_done = (state == adss_pkg::ST_CONV) && ctrl.start && fad_tick
                && (conv_cnt == total_cyc - 6'h01);
    sweep_end = chan_done && last_chan;
  end

  // Trial code: set the top bit after sampling, then resolve one bit per step of step_ticks ticks.
  always_comb
  begin
    next_code = sar_code_o;
    if (conv_cnt == samp_end)
      next_code = RW'(1) << (nbits - 4'h1);
    else if (step)
    begin
      if (!comp_sync)
        next_code = next_code & ~(RW'(1) << bit_idx);
      if (bit_idx != 4'h0)
        next_code = next_code | (RW'(1) << (bit_idx - 4'h1));
    end
  end

  // Trial code register, which is also the code sent to the comparator DAC.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sar_code_o <= '0;
      bit_idx    <= 4'h0;
      step_ph    <= 2'h0;
    end
    else if (state != adss_pkg::ST_CONV || chan_done)
    begin
      sar_code_o <= '0;
      bit_idx    <= 4'h0;
      step_ph    <= 2'h0;
    end
    else if (fad_tick)
    begin
      sar_code_o <= next_code;
      if (conv_cnt == samp_end)
        bit_idx <= nbits - 4'h1;
      else if (step && bit_idx != 4'h0)
        bit_idx <= bit_idx - 4'h1;
      if (conv_cnt == samp_end || step)
        step_ph <= 2'h0;
      else if (conv_cnt > samp_end)
        step_ph <= step_ph + 2'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Sweep sequencing.
  // ---------------------------------------------------------------------------
  // Idle waits for the start flag; conversion walks the channels in order.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state    <= adss_pkg::ST_IDLE;
      chan     <= 3'h0;
      conv_cnt <= 6'h00;
    end
    else
    begin
      case (state)
        adss_pkg::ST_IDLE:
        begin
          if (ctrl.start)
          begin
            state    <= adss_pkg::ST_CONV;
            chan     <= 3'h0;
            conv_cnt <= 6'h00;
          end
        end
        default:
        begin
          if (!ctrl.start || (wr_ctrl && !wdata_i[0]))
            state <= adss_pkg::ST_IDLE;
          else if (chan_done)
          begin
            conv_cnt <= 6'h00;
            if (last_chan)
            begin
              chan <= 3'h0;
              if (ctrl.mode == adss_pkg::MODE_SINGLE)
                state <= adss_pkg::ST_IDLE;
            end
            else
              chan <= chan + 3'h1;
          end
          else if (fad_tick)
            conv_cnt <= conv_cnt + 6'h01;
        end
      endcase
    end
  end

  // Each finished channel lands in its own result register.
  always_ff @(posedge clk_i)
  begin
    if (chan_done)
      result[chan] <= next_code;
  end

  // Sample phase strobe for the sample-and-hold switch.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      sample_o <= 1'h0;
    else
      sample_o <= (state == adss_pkg::ST_CONV) && (conv_cnt < samp_end);
  end

  // Pin selection: channels below the alternate count move to the alternate pins.
  for (genvar g = 0; g < CHANNELS; g++) begin : g_sel
    always_ff @(posedge clk_i)
    begin
      if (reset_i)
        chan_sel_o[g] <= 1'h0;
      else
        chan_sel_o[g] <= (state == adss_pkg::ST_CONV) && (chan == 3'(g))
                         && !(ctrl.input_group_select && g < ALT_PINS);
    end
    if (g < ALT_PINS) begin : g_alt
      always_ff @(posedge clk_i)
      begin
        if (reset_i)
          alt_sel_o[g] <= 1'h0;
        else
          alt_sel_o[g] <= (state == adss_pkg::ST_CONV) && (chan == 3'(g))
                          && ctrl.input_group_select;
      end
    end
  end

  assign busy_o = (state == adss_pkg::ST_CONV);

  // ---------------------------------------------------------------------------
  // Register port.
  // ---------------------------------------------------------------------------
  assign wr_ctrl   = wr_i && (addr_i == adss_pkg::ADDR_CTRL);
  assign wr_status = wr_i && (addr_i == adss_pkg::ADDR_STATUS);
  assign wr_mask   = wr_i && (addr_i == adss_pkg::ADDR_MASK);

  // Control: settings change only while idle; software beats the hardware clear.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ctrl <= adss_pkg::CTRL_RESET;
    else if (wr_ctrl)
    begin
      if (state == adss_pkg::ST_IDLE)
        ctrl <= adss_pkg::adss_ctrl_t'(wdata_i[adss_pkg::CTRL_W-1:0]);
      else
        ctrl.start <= wdata_i[0];
    end
    else if (sweep_end && ctrl.mode == adss_pkg::MODE_SINGLE)
      ctrl.start <= 1'h0;
  end

  // Interrupt request: set by a single sweep end, cleared by ack or a written one.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      status_done <= adss_pkg::STAT_RESET;
    else if (sweep_end && ctrl.mode == adss_pkg::MODE_SINGLE)
      status_done <= 1'h1;
    else if (irq_ack_i || (wr_status && wdata_i[adss_pkg::STAT_DONE_BIT]))
      status_done <= 1'h0;
  end

  // Mask register and level interrupt output.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mask_done <= adss_pkg::MASK_RESET;
      irq_o     <= 1'h0;
    end
    else
    begin
      if (wr_mask)
        mask_done <= wdata_i[adss_pkg::STAT_DONE_BIT];
      irq_o <= status_done && mask_done;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !rd_i)
      rdata_o <= '0;
    else if (addr_i[adss_pkg::RESULT_SEL])
      rdata_o <= DW'(result[addr_i[2:0]]);
    else if (addr_i == adss_pkg::ADDR_CTRL)
      rdata_o <= DW'(ctrl);
    else if (addr_i == adss_pkg::ADDR_STATUS)
      rdata_o <= DW'(status_done);
    else if (addr_i == adss_pkg::ADDR_MASK)
      rdata_o <= DW'(mask_done);
    else if (addr_i == adss_pkg::ADDR_INFO)
      rdata_o <= DW'({busy_o, chan});
    else
      rdata_o <= '0;
  end

  // ---------------------------------------------------------------------------
  // Assertions and cover points.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Helper: clock cycles spent on the current channel.
  logic [7:0] h_clks;
  always_ff @(posedge clk_i)
  begin
    if (reset_i || state != adss_pkg::ST_CONV || chan_done)
      h_clks <= 8'h00;
    else
      h_clks <= h_clks + 8'h01;
  end

  div_two_tick_a: assert property (
    state == adss_pkg::ST_CONV && ctrl.div_sel == adss_pkg::DIV_BY2 && fad_tick
    |=> !fad_tick)
    else $error("Halved converter clock ticked twice in a row.");

  chan_len_sh8_a: assert property (
    chan_done && ctrl.sample_hold && !ctrl.res_10bit && ctrl.div_sel == adss_pkg::DIV_BY2
    |-> h_clks == 8'h37)
    else $error("Channel with sample-and-hold at 8 bits took wrong time.");

  chan_len_nosh10_a: assert property (
    chan_done && !ctrl.sample_hold && ctrl.res_10bit && ctrl.div_sel == adss_pkg::DIV_NONE
    |-> h_clks == 8'h3a)
    else $error("Channel without sample-and-hold at 10 bits took wrong time.");

  chan_range_a: assert property (
    busy_o |-> chan <= {ctrl.sweep_len, 1'h1})
    else $error("Channel index beyond the selected sweep.");

  start_chan0_a: assert property (
    state == adss_pkg::ST_IDLE && ctrl.start |=> busy_o && chan == 3'h0 ##1 busy_o)
    else $error("Sweep did not begin at channel zero.");

  result_store_a: assert property (
    chan_done |=> result[$past(chan)] == $past(next_code))
    else $error("Channel result not stored in its own register.");

  res8_width_a: assert property (
    chan_done && !ctrl.res_10bit |=> result[$past(chan)][RW-1:8] == 2'h0)
    else $error("8-bit result has upper bits set.");

  single_end_a: assert property (
    sweep_end && ctrl.mode == adss_pkg::MODE_SINGLE && !wr_i
    |=> status_done && !ctrl.start && !busy_o ##1 !busy_o)
    else $error("Single sweep end did not flag, clear start and stop.");

  irq_clear_a: assert property (
    irq_ack_i && !sweep_end |=> !status_done ##1 !irq_o)
    else $error("Accepted interrupt request was not cleared.");

  repeat_stop_a: assert property (
    busy_o && wr_ctrl && !wdata_i[0] |=> !busy_o)
    else $error("Repeat sweep kept running after start flag cleared.");

  repeat_no_irq_a: assert property (
    busy_o && ctrl.mode == adss_pkg::MODE_REPEAT |=> !$rose(status_done))
    else $error("Repeat sweep raised the interrupt request.");

  repeat_wrap_a: assert property (
    sweep_end && ctrl.mode == adss_pkg::MODE_REPEAT |=> busy_o && chan == 3'h0)
    else $error("Repeat sweep did not wrap to channel zero.");

  alt_group_a: assert property (
    busy_o && ctrl.input_group_select && chan == 3'h0 |=> alt_sel_o[0] && !chan_sel_o[0])
    else $error("Alternate group pin not selected for channel zero.");

  single_done_c: cover property (sweep_end && ctrl.mode == adss_pkg::MODE_SINGLE ##1 irq_o);
  repeat_wrap_c: cover property (sweep_end && ctrl.mode == adss_pkg::MODE_REPEAT);
  abort_c:       cover property (busy_o && wr_ctrl && !wdata_i[0]);
  alt_group_c:   cover property (alt_sel_o[0]);

endmodule

`default_nettype wire

// ---- tb/adss_analog_model.sv ----
// Behavioural analog front end: pin levels and the comparator.
`timescale 1ns/1ps
`default_nettype none

module adss_analog_model
(
  input  wire logic [adss_pkg::RES_W-1:0] sar_code_i,
  input  wire logic [7:0]                 chan_sel_i,
  input  wire logic [4:0]                 alt_sel_i,
  output logic                            comp_o
);
  logic [9:0] def_v [8];  // Default pin levels, set by the bench.
  logic [9:0] alt_v [5];  // Alternate pin levels, set by the bench.
  logic [9:0] vin;
  logic       hit;

  // -------------------------------------------------------------------------
  // Comparator
  // -------------------------------------------------------------------------
  // With no pin selected the answer toggles, so a stale level never passes.
  always @(sar_code_i or chan_sel_i or alt_sel_i)
  begin
    vin = '0;
    hit = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      if (chan_sel_i[k])
      begin
        vin = def_v[k];
        hit = 1'b1;
      end
    end
    for (int k = 0; k < 5; k++)
    begin
      if (alt_sel_i[k])
      begin
        vin = alt_v[k];
        hit = 1'b1;
      end
    end
    comp_o = hit ? (vin >= sar_code_i) : ~comp_o;
  end
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the converter sweep sequencer.
`timescale 1ns/1ps
`default_nettype none

module tb;
  // -------------------------------------------------------------------------
  // Signals and instances
  // -------------------------------------------------------------------------
  logic                        clk_i     = 1'b0;
  logic                        reset_i   = 1'b1;
  logic [adss_pkg::ADDR_W-1:0] addr_i    = '0;
  logic [adss_pkg::DATA_W-1:0] wdata_i   = '0;
  logic                        wr_i      = 1'b0;
  logic                        rd_i      = 1'b0;
  logic                        irq_ack_i = 1'b0;
  logic [adss_pkg::DATA_W-1:0] rdata_o;
  logic                        irq_o;
  logic                        comp_i;
  logic [adss_pkg::RES_W-1:0]  sar_code_o;
  logic                        sample_o;
  logic                        busy_o;
  logic [7:0]                  chan_sel_o;
  logic [4:0]                  alt_sel_o;
  int                          err_count = 0;
  int                          n_checks  = 0;

  // Free-running 40 MHz clock.
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  adss_sweep_sequencer uut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .irq_ack_i(irq_ack_i), .comp_i(comp_i), .sar_code_o(sar_code_o), .sample_o(sample_o),
    .busy_o(busy_o), .chan_sel_o(chan_sel_o), .alt_sel_o(alt_sel_o));

  adss_analog_model ana (.sar_code_i(sar_code_o), .chan_sel_i(chan_sel_o),
    .alt_sel_i(alt_sel_o), .comp_o(comp_i));

  // -------------------------------------------------------------------------
  // Bus tasks, comparison and closing
  // -------------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data is taken in the one cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    v = rdata_o;
  endtask

  task automatic rc(input logic [3:0] a, input logic [15:0] exp, input string what);
    logic [15:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Reference result of one channel; 8-bit results saturate in the low bits.
  function automatic logic [15:0] expect_res(int ch, logic grp, logic r10);
    int v;
    v = (grp && ch < 5) ? int'(ana.alt_v[ch]) : int'(ana.def_v[ch]);
    if (!r10 && v > 255)
      v = 255;
    return 16'(v);
  endfunction

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  // One single sweep; each index picks another division code, resolution and length.
  task automatic single_run(input int i);
    adss_pkg::adss_ctrl_t c;
    int n;
    int t;
    int dv;
    int cnt;
    logic smp;
    c = adss_pkg::CTRL_RESET;
    c.sweep_len = 2'(i);
    c.input_group_select = ~i[0];
    c.sample_hold = (i == 0 || i == 3);  // fAD never drops below 10 MHz here.
    c.res_10bit = ~i[0];
    c.div_sel = 2'(i);
    c.mode = adss_pkg::MODE_SINGLE;
    c.start = 1'b1;
    n = 2 * i + 2;
    t = c.sample_hold ? (c.res_10bit ? 33 : 28) : (c.res_10bit ? 59 : 49);
    dv = (i == 0) ? 4 : (i == 1) ? 2 : 1;
    for (int k = 0; k < 8; k++)
      ana.def_v[k] = (i == 0) ? 10'($urandom) : {10{1'($urandom_range(1))}};
    for (int k = 0; k < 5; k++)
      ana.alt_v[k] = (i == 0) ? 10'($urandom) : {10{1'($urandom_range(1))}};
    wr(adss_pkg::ADDR_MASK, {15'h0, 1'(i != 2)});
    wr(adss_pkg::ADDR_CTRL, 16'(c));
    cnt = 0;
    smp = 1'b0;
    for (int w = 0; w < 4000 && !(cnt > 0 && busy_o !== 1'b1); w++)
    begin
      @(posedge clk_i);
      #1;
      if (busy_o === 1'b1)
        cnt++;
      smp = smp | (sample_o === 1'b1);
    end
    chk("sample seen", {15'h0, smp}, 16'h1);
    chk("busy length", 16'(cnt >= n * t * dv - 4 && cnt <= n * t * dv + 4), 16'h1);
    repeat (2) @(posedge clk_i);
    #1;
    chk("irq raised", {15'h0, irq_o}, {15'h0, 1'(i != 2)});
    chk("stopped", {15'h0, busy_o}, 16'h0);
    chk("sample idle", {15'h0, sample_o}, 16'h0);
    rc(adss_pkg::ADDR_STATUS, 16'h1, "status done");
    rc(adss_pkg::ADDR_CTRL, 16'(c) & 16'hfffe, "start cleared");
    for (int k = 0; k < n; k++)
      rc(4'(8 + k), expect_res(k, c.input_group_select, c.res_10bit), "result");
    if (i[0])
    begin
      @(posedge clk_i);
      irq_ack_i <= 1'b1;
      @(posedge clk_i);
      irq_ack_i <= 1'b0;
    end
    else
      wr(adss_pkg::ADDR_STATUS, 16'h1);
    repeat (2) @(posedge clk_i);
    #1;
    chk("irq cleared", {15'h0, irq_o}, 16'h0);
    rc(adss_pkg::ADDR_STATUS, 16'h0, "status cleared");
  endtask

  // Repeat sweep over two channels: order, wrap, fresh results, no interrupt.
  task automatic repeat_run();
    adss_pkg::adss_ctrl_t c;
    adss_pkg::adss_ctrl_t c2;
    int q[$];
    logic [15:0] d;
    logic irq_seen;
    c = adss_pkg::CTRL_RESET;
    c.div_sel = adss_pkg::DIV_NONE;
    c.sample_hold = 1'b1;
    c.mode = adss_pkg::MODE_REPEAT;
    c.start = 1'b1;
    irq_seen = 1'b0;
    ana.def_v[0] = '0;
    ana.def_v[1] = '1;
    wr(adss_pkg::ADDR_MASK, 16'h1);
    wr(adss_pkg::ADDR_CTRL, 16'(c));
    for (int w = 0; w < 90; w++)
    begin
      rd(adss_pkg::ADDR_INFO, d);
      irq_seen = irq_seen | (irq_o !== 1'b0);
      if (q.size() == 0 || q[$] != int'(d[2:0]))
        q.push_back(int'(d[2:0]));
    end
    chk("channel count", 16'(q.size() >= 5), 16'h1);
    for (int k = 0; k < 5 && k < q.size(); k++)
      chk("channel order", 16'(q[k]), 16'(k % 2));
    chk("no irq", {15'h0, irq_seen}, 16'h0);
    rc(adss_pkg::ADDR_STATUS, 16'h0, "no status");
    rc(4'h8, 16'h0000, "result0");
    rc(4'h9, 16'h00ff, "result1");
    ana.def_v[0] = '1;
    ana.def_v[1] = '0;
    repeat (120) @(posedge clk_i);
    rc(4'h8, 16'h00ff, "result0 again");
    rc(4'h9, 16'h0000, "result1 again");
    c2 = c;
    c2.sweep_len = 2'h3;
    c2.res_10bit = 1'b1;
    wr(adss_pkg::ADDR_CTRL, 16'(c2));
    rc(adss_pkg::ADDR_CTRL, 16'(c), "ctrl frozen");
    c.start = 1'b0;
    wr(adss_pkg::ADDR_CTRL, 16'(c));
    repeat (2) @(posedge clk_i);
    #1;
    chk("stop", {15'h0, busy_o}, 16'h0);
    rc(adss_pkg::ADDR_STATUS, 16'h0, "no status after stop");
  endtask

  // -------------------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------------------
  // Reset, register defaults, unmapped space, then the sweeps.
  initial
  begin
    void'($urandom(32'h95b2c5a4));
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    chk("irq at reset", {15'h0, irq_o}, 16'h0);
    chk("busy at reset", {15'h0, busy_o}, 16'h0);
    rc(adss_pkg::ADDR_CTRL, 16'h0, "ctrl reset");
    rc(adss_pkg::ADDR_STATUS, 16'h0, "status reset");
    rc(adss_pkg::ADDR_MASK, 16'h0, "mask reset");
    rc(adss_pkg::ADDR_INFO, 16'h0, "info reset");
    wr(4'h5, 16'hffff);
    rc(4'h5, 16'h0, "unmapped");
    rc(4'h4, 16'h0, "unmapped");
    for (int i = 0; i < 4; i++)
      single_run(i);
    repeat_run();
    summarize();
  end

  // Cuts a hang short; the whole run needs under two thousand cycles.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    summarize();
  end
endmodule

`default_nettype wire
